//--- rtl/cmct_regs.svh
// Offsets, reset values and widths for the channel minimum-code trackers
`ifndef CMCT_REGS_SVH
`define CMCT_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CMCT_IDX_CHAN0_MIN_CODE_LOW  8'h80
`define CMCT_IDX_CHAN0_MIN_CODE_HIGH 8'h81
`define CMCT_IDX_CHAN1_MIN_CODE_LOW  8'h82
`define CMCT_IDX_CHAN1_MIN_CODE_HIGH 8'h83
`define CMCT_IDX_CHAN2_MIN_CODE_LOW  8'h84
`define CMCT_IDX_CHAN2_MIN_CODE_HIGH 8'h85
`define CMCT_IDX_CHAN3_MIN_CODE_LOW  8'h86
`define CMCT_IDX_CHAN3_MIN_CODE_HIGH 8'h87
`define CMCT_IDX_CHAN4_MIN_CODE_LOW  8'h88

// ----------------------------------------------------------------
// Values and sizes
// ----------------------------------------------------------------
`define CMCT_MIN_RESET    8'hFF
`define CMCT_NUM_CHAN     5
`define CMCT_NUM_INPUTS   8
`define CMCT_READ_ZERO    32'h0000_0000

`endif

//--- rtl/cmct_pkg.sv
// Types shared by the channel minimum-code trackers
package cmct_pkg;
    typedef logic [7:0]  cmct_byte_t;
    typedef logic [15:0] cmct_code_t;
    typedef logic [2:0]  cmct_chan_t;
endpackage

//--- rtl/cmct_tracker.sv
// One channel's minimum-code tracker, low and high byte
`timescale 1ns/1ps
`include "cmct_regs.svh"
module cmct_tracker
    import cmct_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       upd_i,
    input  wire cmct_code_t code_i,
    input  wire logic       rd_lo_i,
    input  wire logic       rd_hi_i,
    output cmct_byte_t      lo_o,
    output cmct_byte_t      hi_o
);
    cmct_byte_t lo_reg;
    cmct_byte_t hi_reg;
    cmct_byte_t lo_next;
    cmct_byte_t hi_next;
    wire logic  lower;
    wire logic  take;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    // Compare against bytes as they stand; a byte just reloaded counts as 0xFF
    assign lower   = code_i < {hi_reg, lo_reg};
    assign take    = upd_i && lower;
    // A conversion landing with the read-reload wins over the reload
    assign lo_next = rd_lo_i ? (upd_i ? code_i[7:0] : `CMCT_MIN_RESET)
                             : (take ? code_i[7:0] : lo_reg);
    assign hi_next = rd_hi_i ? (upd_i ? code_i[15:8] : `CMCT_MIN_RESET)
                             : (take ? code_i[15:8] : hi_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_reg <= `CMCT_MIN_RESET;
            hi_reg <= `CMCT_MIN_RESET;
        end else begin
            lo_reg <= lo_next;
            hi_reg <= hi_next;
        end
    end

    assign lo_o = lo_reg;
    assign hi_o = hi_reg;
endmodule

//--- rtl/cmct_bank.sv
// Channel minimum-code tracker bank with classic Wishbone slave
`timescale 1ns/1ps
`include "cmct_regs.svh"
module cmct_bank
    import cmct_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        conv_valid_i,
    input  wire cmct_chan_t  conv_chan_i,
    input  wire cmct_code_t  conv_code_i,
    input  wire logic [7:0]  chan_analog_i
);
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic             ack_reg;
    logic      [31:0] dat_reg;
    wire logic        ack_next;
    wire logic [31:0] dat_next;
    wire logic        req;
    wire logic        rd_go;
    wire logic        in_page;
    wire logic [7:0]  idx;
    wire logic        mapped;

    // Writes and byte lanes are accepted and ignored: the bank is read-only
    assign req     = cyc_i && stb_i && !ack_reg;
    assign rd_go   = req && !we_i;
    assign idx     = adr_i[9:2];
    assign in_page = adr_i[31:10] == 22'h00_0000;

    // ----------------------------------------------------------------
    // Register hits
    // ----------------------------------------------------------------
    wire logic        hit_c0_lo;
    wire logic        hit_c0_hi;
    wire logic        hit_c1_lo;
    wire logic        hit_c1_hi;
    wire logic        hit_c2_lo;
    wire logic        hit_c2_hi;
    wire logic        hit_c3_lo;
    wire logic        hit_c3_hi;
    wire logic        hit_c4_lo;

    // Full compare of every index, so nothing aliases into the range
    assign hit_c0_lo = in_page && idx == `CMCT_IDX_CHAN0_MIN_CODE_LOW;
    assign hit_c0_hi = in_page && idx == `CMCT_IDX_CHAN0_MIN_CODE_HIGH;
    assign hit_c1_lo = in_page && idx == `CMCT_IDX_CHAN1_MIN_CODE_LOW;
    assign hit_c1_hi = in_page && idx == `CMCT_IDX_CHAN1_MIN_CODE_HIGH;
    assign hit_c2_lo = in_page && idx == `CMCT_IDX_CHAN2_MIN_CODE_LOW;
    assign hit_c2_hi = in_page && idx == `CMCT_IDX_CHAN2_MIN_CODE_HIGH;
    assign hit_c3_lo = in_page && idx == `CMCT_IDX_CHAN3_MIN_CODE_LOW;
    assign hit_c3_hi = in_page && idx == `CMCT_IDX_CHAN3_MIN_CODE_HIGH;
    assign hit_c4_lo = in_page && idx == `CMCT_IDX_CHAN4_MIN_CODE_LOW;
    assign mapped    = hit_c0_lo || hit_c0_hi || hit_c1_lo
                    || hit_c1_hi || hit_c2_lo || hit_c2_hi
                    || hit_c3_lo || hit_c3_hi || hit_c4_lo;

    // ----------------------------------------------------------------
    // Read and conversion strobes
    // ----------------------------------------------------------------
    wire logic        rd_c0_lo;
    wire logic        rd_c0_hi;
    wire logic        rd_c1_lo;
    wire logic        rd_c1_hi;
    wire logic        rd_c2_lo;
    wire logic        rd_c2_hi;
    wire logic        rd_c3_lo;
    wire logic        rd_c3_hi;
    wire logic        rd_c4_lo;
    wire logic        rd_c4_hi;
    wire logic        upd_c0;
    wire logic        upd_c1;
    wire logic        upd_c2;
    wire logic        upd_c3;
    wire logic        upd_c4;

    assign rd_c0_lo = rd_go && hit_c0_lo;
    assign rd_c0_hi = rd_go && hit_c0_hi;
    assign rd_c1_lo = rd_go && hit_c1_lo;
    assign rd_c1_hi = rd_go && hit_c1_hi;
    assign rd_c2_lo = rd_go && hit_c2_lo;
    assign rd_c2_hi = rd_go && hit_c2_hi;
    assign rd_c3_lo = rd_go && hit_c3_lo;
    assign rd_c3_hi = rd_go && hit_c3_hi;
    assign rd_c4_lo = rd_go && hit_c4_lo;
    // Channel four's high byte is served outside this bank, so never reloaded here
    assign rd_c4_hi = 1'b0;

    // Only analog-configured channels feed their trackers
    assign upd_c0   = conv_valid_i && conv_chan_i == 3'h0
                      && chan_analog_i[0];
    assign upd_c1   = conv_valid_i && conv_chan_i == 3'h1
                      && chan_analog_i[1];
    assign upd_c2   = conv_valid_i && conv_chan_i == 3'h2
                      && chan_analog_i[2];
    assign upd_c3   = conv_valid_i && conv_chan_i == 3'h3
                      && chan_analog_i[3];
    assign upd_c4   = conv_valid_i && conv_chan_i == 3'h4
                      && chan_analog_i[4];

    // ----------------------------------------------------------------
    // Trackers
    // ----------------------------------------------------------------
    wire cmct_byte_t  chan0_lowest_code_lo;
    wire cmct_byte_t  chan0_lowest_code_hi;
    wire cmct_byte_t  chan1_lowest_code_lo;
    wire cmct_byte_t  chan1_lowest_code_hi;
    wire cmct_byte_t  chan2_lowest_code_lo;
    wire cmct_byte_t  chan2_lowest_code_hi;
    wire cmct_byte_t  chan3_lowest_code_lo;
    wire cmct_byte_t  chan3_lowest_code_hi;
    wire cmct_byte_t  chan4_lowest_code_lo;
    wire cmct_byte_t  chan4_lowest_code_hi;

    cmct_tracker u_trk_c0 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .upd_i   (upd_c0),
        .code_i  (conv_code_i),
        .rd_lo_i (rd_c0_lo),
        .rd_hi_i (rd_c0_hi),
        .lo_o    (chan0_lowest_code_lo),
        .hi_o    (chan0_lowest_code_hi)
    );

    cmct_tracker u_trk_c1 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .upd_i   (upd_c1),
        .code_i  (conv_code_i),
        .rd_lo_i (rd_c1_lo),
        .rd_hi_i (rd_c1_hi),
        .lo_o    (chan1_lowest_code_lo),
        .hi_o    (chan1_lowest_code_hi)
    );

    cmct_tracker u_trk_c2 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .upd_i   (upd_c2),
        .code_i  (conv_code_i),
        .rd_lo_i (rd_c2_lo),
        .rd_hi_i (rd_c2_hi),
        .lo_o    (chan2_lowest_code_lo),
        .hi_o    (chan2_lowest_code_hi)
    );

    cmct_tracker u_trk_c3 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .upd_i   (upd_c3),
        .code_i  (conv_code_i),
        .rd_lo_i (rd_c3_lo),
        .rd_hi_i (rd_c3_hi),
        .lo_o    (chan3_lowest_code_lo),
        .hi_o    (chan3_lowest_code_hi)
    );

    // High byte kept only for the compare; it is not readable in this bank
    cmct_tracker u_trk_c4 (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .upd_i   (upd_c4),
        .code_i  (conv_code_i),
        .rd_lo_i (rd_c4_lo),
        .rd_hi_i (rd_c4_hi),
        .lo_o    (chan4_lowest_code_lo),
        .hi_o    (chan4_lowest_code_hi)
    );

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    wire cmct_byte_t  rd_byte;
    wire logic [31:0] rd_word;

    // No hit leaves the byte at zero: unmapped reads answer zero, not an error
    assign rd_byte  = ({8{hit_c0_lo}} & chan0_lowest_code_lo)
                    | ({8{hit_c0_hi}} & chan0_lowest_code_hi)
                    | ({8{hit_c1_lo}} & chan1_lowest_code_lo)
                    | ({8{hit_c1_hi}} & chan1_lowest_code_hi)
                    | ({8{hit_c2_lo}} & chan2_lowest_code_lo)
                    | ({8{hit_c2_hi}} & chan2_lowest_code_hi)
                    | ({8{hit_c3_lo}} & chan3_lowest_code_lo)
                    | ({8{hit_c3_hi}} & chan3_lowest_code_hi)
                    | ({8{hit_c4_lo}} & chan4_lowest_code_lo);
    assign rd_word  = {24'h00_0000, rd_byte};
    // The byte leaves as it stood before this edge's reload
    assign dat_next = rd_go ? rd_word : `CMCT_READ_ZERO;
    assign ack_next = req;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= `CMCT_READ_ZERO;
        end else begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
endmodule

//--- verif/cmct_bank_props.sv
// Bus and reset checks for the minimum-code tracker bank
`timescale 1ns/1ps
module cmct_bank_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        conv_valid_i
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire req    = cyc_i && stb_i && !ack_o;
    wire rd     = req && !we_i;
    wire mapped = adr_i[31:10] == 22'h0 && adr_i[9:2] >= 8'h80 && adr_i[9:2] <= 8'h88;
    chk_ack_follows: assert property (req |=> ack_o)
        else $error("request not acked");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    chk_idle_quiet: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data without ack");
    chk_byte_only: assert property (dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_write_null: assert property (req && we_i |=> dat_o == 32'h0)
        else $error("write returned data");
    chk_unmapped_null: assert property (rd && !mapped |=> dat_o == 32'h0)
        else $error("unmapped read returned data");
    // No conversion between the reads, so the byte must still be the reload value
    chk_read_reload: assert property (rd && mapped && !conv_valid_i ##1 !conv_valid_i [*2]
        ##1 rd && adr_i == $past(adr_i, 3) |=> dat_o[7:0] == 8'hFF)
        else $error("byte not reloaded after read");
    chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !dat_o)
        else $error("bus active in reset");
    cover property (rd && mapped);
    cover property (req && we_i);
    cover property (conv_valid_i);
endmodule

//--- verif/tb.sv
// Self-checking bench for the minimum-code tracker bank
`timescale 1ns/1ps
module tb;
    import cmct_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, conv_valid_i = 0;
    logic [31:0] adr_i = 0, dat_i = 0, dat_o, rd;
    logic [3:0]  sel_i = 4'hF;
    logic        ack_o;
    cmct_chan_t  conv_chan_i = 0;
    cmct_code_t  conv_code_i = 0;
    logic [7:0]  chan_analog_i = 8'hFF, lo, hi;
    int          miscompares = 0, checks_done = 0, cycles = 0;
    cmct_bank dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o,
        .ack_o, .conv_valid_i, .conv_chan_i, .conv_code_i, .chan_analog_i);
    initial forever #50 clk_i = ~clk_i;
    task automatic wb(input logic [7:0] idx, input logic w);
        adr_i <= {22'h0, idx, 2'h0};
        we_i  <= w;
        dat_i <= {24'h00_0000, idx};
        sel_i <= 4'hF;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic conv(input cmct_chan_t ch, input cmct_code_t c);
        conv_chan_i  <= ch;
        conv_code_i  <= c;
        conv_valid_i <= 1'b1;
        @(posedge clk_i);
        conv_valid_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Whole run is about 130 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 8'h80; i <= 8'h88; i++) begin
            wb(8'(i), 1'b0);
            chk("reset value", rd[7:0], 8'hFF);
        end
        wb(8'h84, 1'b1);
        wb(8'h84, 1'b0);
        chk("after write", rd[7:0], 8'hFF);
        wb(8'h89, 1'b0);
        chk("unmapped", rd[7:0], 8'h00);
        for (int n = 0; n < 5; n++) begin
            lo = 8'h20 + 8'(n);
            hi = 8'h10 + 8'(n);
            conv(3'(n), 16'h7FFF);
            conv(3'(n), {hi, lo});
            conv(3'(n), {hi, lo} + 16'h0001);
            wb(8'h80 + 8'(2 * n), 1'b0);
            chk("low byte", rd[7:0], lo);
            if (n < 4) begin
                wb(8'h81 + 8'(2 * n), 1'b0);
                chk("high byte", rd[7:0], hi);
            end
            wb(8'h80 + 8'(2 * n), 1'b0);
            chk("reloaded", rd[7:0], 8'hFF);
        end
        conv(3'h0, 16'h3456);
        wb(8'h80, 1'b0);
        chk("chan0 low", rd[7:0], 8'h56);
        wb(8'h81, 1'b0);
        chk("chan0 high", rd[7:0], 8'h34);
        chan_analog_i <= 8'hFD;
        conv(3'h1, 16'h0000);
        wb(8'h82, 1'b0);
        chk("digital channel", rd[7:0], 8'hFF);
        give_verdict();
    end
endmodule
bind cmct_bank cmct_bank_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_o, .ack_o, .conv_valid_i);
